// file: include/ash_fifo_if.sv
`timescale 1ns/10ps
interface ash_fifo_if #(parameter int W = 16);
  logic [W-1:0] in_data;
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] out_data;
  logic         out_valid;
  logic         out_ready;
  modport fifo (input in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
  modport user (output in_data, in_valid, out_ready, input in_ready, out_data, out_valid);
endinterface

// file: include/ash_pkg.sv
// How it works
// R1 - while a register write is in progress the data output stays undriven.
// R2 - while a register read is in progress the data input is ignored.
// R3 - write data are shifted in most significant bit first.
// R4 - read data are shifted out most significant bit first.
// R5 - the host is the serial master and rests the serial clock high between transfers.
// R6 - with select tied low the host learns of new data from bit 7 of the command byte.
// R7 - the host may instead watch the active-low sample ready pin.
// R8 - a framing host drives select low while either of its frame syncs is active.
// R9 - the host keeps the serial clock at or below 3 MHz.
// R10 - data input and data output may share one wire, since only reads drive it.
// R11 - after power-up the host first writes a command byte that selects the clock register.
// R12 - the clock-divide bit halves the modulator clock enable rate.
// R13 - the host then addresses the setup register and writes it, starting a calibration.
// R14 - the host loops on sample ready and data register reads until it has enough samples.
// R15 - sample ready falls when a new word is loaded and rises when a data read ends.
// R16 - 32 serial clocks with the input held at one return the port to await a command byte.
// R17 - right after the eighth bit of a command byte the selected transfer begins.
package ash_pkg;
  typedef enum logic [2:0] {
    ST_COMM  = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b100
  } ash_state_e;

  // ==========================================================
  // register selects and command byte layout
  localparam logic [2:0] RS_COMM   = 3'h0;
  localparam logic [2:0] RS_SETUP  = 3'h1;
  localparam logic [2:0] RS_CLOCK  = 3'h2;
  localparam logic [2:0] RS_DATA   = 3'h3;
  localparam logic [2:0] RS_OFFSET = 3'h6;
  localparam logic [2:0] RS_GAIN   = 3'h7;
  localparam int COMM_READY_BIT = 7;
  localparam int COMM_RS_LSB    = 4;
  localparam int COMM_RW_BIT    = 3;
  localparam int COMM_STBY_BIT  = 2;
  localparam int COMM_CH_LSB    = 0;
  localparam int CLK_DIV_BIT     = 3;
  localparam int SETUP_FILTER_SYNC_HOLD_BIT = 0;
  localparam int SETUP_MODE_LSB  = 6;

  // ==========================================================
  // widths, lengths and reset values
  localparam int SAMPLE_W   = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int SHIFT_W    = 24;
  localparam logic [4:0] LEN_BYTE = 5'h08;
  localparam logic [4:0] LEN_WORD = 5'h10;
  localparam logic [4:0] LEN_WIDE = 5'h18;
  localparam logic [5:0] ONES_RESET_COUNT = 6'h20;
  localparam logic [6:0] COMM_RST   = 7'h00;
  localparam logic [7:0] SETUP_RST  = 8'h00;
  localparam logic [7:0] CLOCK_RST  = 8'h00;
  localparam logic [23:0] CAL_RST   = 24'h000000;

  // transfer length in bits for a register select
  function automatic logic [4:0] reg_len(input logic [2:0] rs);
    unique case (rs)
      RS_DATA:            reg_len = LEN_WORD;
      RS_OFFSET, RS_GAIN: reg_len = LEN_WIDE;
      default:            reg_len = LEN_BYTE;
    endcase
  endfunction
endpackage

// file: rtl/ash_fifo.sv
`timescale 1ns/10ps
module ash_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  ash_fifo_if.fifo  q
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [AW:0]   cnt_reg, cnt_next, held;
  logic          ready_reg, ready_next, valid_reg, valid_next;
  logic [W-1:0]  data_reg, data_next;
  logic          push, fetch, pop;

  // ==========================================================
  // pointers, fill count and registered head word
  // the count includes the head word, so the buffer never holds more than DEPTH
  always_comb begin
    push        = q.in_valid & ready_reg;
    pop         = valid_reg & q.out_ready;
    held        = cnt_reg - {{AW{1'b0}}, valid_reg}; // words still in storage
    fetch       = (held != '0) & (~valid_reg | pop);
    wr_ptr_next = push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = fetch ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    cnt_next    = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    ready_next  = (cnt_next != FULL_CNT);
    valid_next  = fetch | (valid_reg & ~pop);
    data_next   = fetch ? mem[rd_ptr_reg] : data_reg;
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
      ready_reg  <= 1'b0;
      valid_reg  <= 1'b0;
      data_reg   <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg    <= cnt_next;
      ready_reg  <= ready_next;
      valid_reg  <= valid_next;
      data_reg   <= data_next;
    end
  end

  // storage has no reset; only words behind the count are ever read
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= q.in_data;
    end
  end

  assign q.in_ready  = ready_reg;
  assign q.out_valid = valid_reg;
  assign q.out_data  = data_reg;

  property p_full_refuses;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (cnt_reg == FULL_CNT) |-> !ready_reg;
  endproperty
  a_full_refuses: assert property (p_full_refuses) else $error("fifo full but ready");
endmodule

// file: rtl/ash_serial_port.sv
`timescale 1ns/10ps
module ash_serial_port (
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        din_i,
  output logic             dout_o,
  output logic             dout_oe_o,
  output logic             sample_ready_n_o,
  input  wire logic [15:0] sample_word_i,
  input  wire logic        sample_valid_i,
  output logic             word_ready_o,
  output logic [1:0]       channel_o,
  output logic             standby_o,
  output logic [7:0]       setup_o,
  output logic [7:0]       clock_cfg_o,
  output logic [23:0]      offset_o,
  output logic [23:0]      gain_o,
  output logic             filter_sync_hold_o,
  output logic             calib_start_o,
  output logic             mod_clk_en_o
);
  // ==========================================================
  // pin synchronisers: stage 1 feeds stage 2 only
  logic [2:0] sync1_reg, sync2_reg, prev_reg;
  logic       rise, fall, sel, din_s;

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
      prev_reg  <= 3'h7;
    end else begin
      sync1_reg <= {sclk_i, cs_n_i, din_i};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // edges on the clean copies; sclk is far slower than core_clk
  assign rise  = sync2_reg[2] & ~prev_reg[2];
  assign fall  = ~sync2_reg[2] & prev_reg[2];
  assign sel   = ~sync2_reg[1];
  assign din_s = sync2_reg[0];

  // ==========================================================
  // sample buffer in front of the data register
  ash_fifo_if #(.W(ash_pkg::SAMPLE_W)) fq ();

  ash_fifo #(.W(ash_pkg::SAMPLE_W), .DEPTH(ash_pkg::FIFO_DEPTH)) u_fifo (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .q          (fq.fifo)
  );

  assign fq.in_data  = sample_word_i;
  assign fq.in_valid = sample_valid_i;

  // ==========================================================
  // serial engine state
  ash_pkg::ash_state_e state_reg, state_next;
  logic [4:0]  bit_cnt_reg, bit_cnt_next, len_reg, len_next;
  logic [5:0]  ones_reg, ones_next;
  logic [23:0] in_sh_reg, in_sh_next, out_sh_reg, out_sh_next;
  logic [6:0]  comm_reg, comm_next;
  logic [7:0]  setup_reg, setup_next, clock_reg, clock_next;
  logic [23:0] offset_reg, offset_next, gain_reg, gain_next;
  logic [15:0] data_reg, data_next;
  logic        ready_n_reg, ready_n_next, oe_reg, oe_next;
  logic        cal_reg, cal_next, men_reg, men_next, load;
  logic [23:0] shifted;
  logic [7:0]  cbyte;
  logic [2:0]  rs;

  assign rs      = comm_reg[ash_pkg::COMM_RS_LSB +: 3];
  assign shifted = {in_sh_reg[22:0], din_s}; // msb arrives first [R3]
  assign cbyte   = shifted[7:0];
  // a word waits in the buffer until the previous one was read
  assign load = ready_n_reg & fq.out_valid &
                ~(state_reg == ash_pkg::ST_READ && rs == ash_pkg::RS_DATA);
  assign fq.out_ready = load;

  // read image, left aligned so bit 23 always leaves first
  function automatic logic [23:0] read_image(input logic [2:0] s, input logic [6:0] c,
                                             input logic r, input logic [7:0] su,
                                             input logic [7:0] ck, input logic [15:0] d,
                                             input logic [23:0] of, input logic [23:0] g);
    unique case (s)
      ash_pkg::RS_COMM:   read_image = {r, c, 16'h0000};
      ash_pkg::RS_SETUP:  read_image = {su, 16'h0000};
      ash_pkg::RS_CLOCK:  read_image = {ck, 16'h0000};
      ash_pkg::RS_DATA:   read_image = {d, 8'h00};
      ash_pkg::RS_OFFSET: read_image = of;
      ash_pkg::RS_GAIN:   read_image = g;
      default:            read_image = 24'h000000;
    endcase
  endfunction

  // next state of the serial engine and the register file
  always_comb begin
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg;
    len_next     = len_reg;
    ones_next    = ones_reg;
    in_sh_next   = in_sh_reg;
    out_sh_next  = out_sh_reg;
    comm_next    = comm_reg;
    setup_next   = setup_reg;
    clock_next   = clock_reg;
    offset_next  = offset_reg;
    gain_next    = gain_reg;
    data_next    = data_reg;
    ready_n_next = ready_n_reg;
    cal_next     = 1'b0;
    if (!sel) begin
      bit_cnt_next = 5'h00;
      ones_next    = 6'h00;
    end else if (rise && state_reg != ash_pkg::ST_READ && din_s &&
                 ones_reg == ash_pkg::ONES_RESET_COUNT - 6'h01) begin
      state_next   = ash_pkg::ST_COMM; // registers keep their contents [R16]
      bit_cnt_next = 5'h00;
      ones_next    = 6'h00;
    end else if (rise) begin
      if (state_reg != ash_pkg::ST_READ) begin
        ones_next  = din_s ? ones_reg + 6'h01 : 6'h00; // [R16]
        in_sh_next = shifted;                          // [R3]
      end
      bit_cnt_next = bit_cnt_reg + 5'h01;
      unique case (state_reg)
        ash_pkg::ST_COMM: begin
          if (bit_cnt_reg == ash_pkg::LEN_BYTE - 5'h01) begin
            bit_cnt_next = 5'h00;
            // a byte with bit 7 set is not a command and is dropped
            if (!cbyte[ash_pkg::COMM_READY_BIT]) begin
              comm_next = cbyte[6:0];
              len_next  = ash_pkg::reg_len(cbyte[ash_pkg::COMM_RS_LSB +: 3]);
              if (cbyte[ash_pkg::COMM_RW_BIT]) begin
                state_next  = ash_pkg::ST_READ; // next transfer starts at once [R17]
                out_sh_next = read_image(cbyte[ash_pkg::COMM_RS_LSB +: 3], cbyte[6:0],
                                         ready_n_reg, setup_reg, clock_reg, data_reg,
                                         offset_reg, gain_reg);
              end else if (cbyte[ash_pkg::COMM_RS_LSB +: 3] != ash_pkg::RS_COMM) begin
                state_next = ash_pkg::ST_WRITE; // [R17]
              end
            end
          end
        end
        ash_pkg::ST_WRITE: begin
          if (bit_cnt_reg == len_reg - 5'h01) begin
            state_next   = ash_pkg::ST_COMM;
            bit_cnt_next = 5'h00;
            unique case (rs)
              ash_pkg::RS_SETUP: begin
                setup_next = shifted[7:0];
                cal_next   = shifted[ash_pkg::SETUP_MODE_LSB +: 2] != 2'b00;
              end
              ash_pkg::RS_CLOCK:  clock_next  = shifted[7:0];
              ash_pkg::RS_OFFSET: offset_next = shifted;
              ash_pkg::RS_GAIN:   gain_next   = shifted;
              default: ; // data and test writes are absorbed
            endcase
          end
        end
        ash_pkg::ST_READ: begin
          // input bits are not looked at while reading [R2]
          if (bit_cnt_reg == len_reg - 5'h01) begin
            state_next   = ash_pkg::ST_COMM;
            bit_cnt_next = 5'h00;
            if (rs == ash_pkg::RS_DATA) begin
              ready_n_next = 1'b1; // read finished [R15]
            end
          end
        end
      endcase
    end
    // shift on the falling edge; the first bit is already out [R4]
    if (sel && fall && state_reg == ash_pkg::ST_READ && bit_cnt_reg != 5'h00) begin
      out_sh_next = {out_sh_reg[22:0], 1'b0};
    end
    if (load) begin
      data_next    = fq.out_data;
      ready_n_next = 1'b0; // new word available [R15]
    end
    // drive only during reads so the pins may share one wire [R1] [R10]
    oe_next  = (state_next == ash_pkg::ST_READ) & sel;
    // modulator clock enable, halved when the divide bit is set [R12]
    men_next = clock_reg[ash_pkg::CLK_DIV_BIT] ? ~men_reg : 1'b1;
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      state_reg   <= ash_pkg::ST_COMM;
      bit_cnt_reg <= 5'h00;
      len_reg     <= ash_pkg::LEN_BYTE;
      ones_reg    <= 6'h00;
      in_sh_reg   <= 24'h000000;
      out_sh_reg  <= 24'h000000;
      comm_reg    <= ash_pkg::COMM_RST;
      setup_reg   <= ash_pkg::SETUP_RST;
      clock_reg   <= ash_pkg::CLOCK_RST;
      offset_reg  <= ash_pkg::CAL_RST;
      gain_reg    <= ash_pkg::CAL_RST;
      data_reg    <= 16'h0000;
      ready_n_reg <= 1'b1;
      oe_reg      <= 1'b0;
      cal_reg     <= 1'b0;
      men_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      len_reg     <= len_next;
      ones_reg    <= ones_next;
      in_sh_reg   <= in_sh_next;
      out_sh_reg  <= out_sh_next;
      comm_reg    <= comm_next;
      setup_reg   <= setup_next;
      clock_reg   <= clock_next;
      offset_reg  <= offset_next;
      gain_reg    <= gain_next;
      data_reg    <= data_next;
      ready_n_reg <= ready_n_next;
      oe_reg      <= oe_next;
      cal_reg     <= cal_next;
      men_reg     <= men_next;
    end
  end

  // outputs come straight from flops
  assign dout_o             = out_sh_reg[23];
  assign dout_oe_o          = oe_reg;
  assign sample_ready_n_o   = ready_n_reg;
  assign word_ready_o       = fq.in_ready;
  assign channel_o          = comm_reg[ash_pkg::COMM_CH_LSB +: 2];
  assign standby_o          = comm_reg[ash_pkg::COMM_STBY_BIT];
  assign setup_o            = setup_reg;
  assign clock_cfg_o        = clock_reg;
  assign offset_o           = offset_reg;
  assign gain_o             = gain_reg;
  assign filter_sync_hold_o = setup_reg[ash_pkg::SETUP_FILTER_SYNC_HOLD_BIT];
  assign calib_start_o      = cal_reg;
  assign mod_clk_en_o       = men_reg;

  // ==========================================================
  // checks
  sequence s_read_last;
    state_reg == ash_pkg::ST_READ && rs == ash_pkg::RS_DATA && sel && rise &&
    bit_cnt_reg == len_reg - 5'h01;
  endsequence
  sequence s_cmd_read;
    state_reg == ash_pkg::ST_COMM && sel && rise && bit_cnt_reg == 5'h07 &&
    !cbyte[7] && cbyte[ash_pkg::COMM_RW_BIT] && !(din_s && ones_reg == 6'h1F);
  endsequence

  property p_no_drive_write;
    @(posedge core_clk_i) disable iff (!nrst_i)
      state_reg == ash_pkg::ST_WRITE |=> !dout_oe_o;
  endproperty
  a_no_drive_write: assert property (p_no_drive_write) else $error("driven in write"); // [R1]
  property p_ignore_din;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg == ash_pkg::ST_READ && rise) |=> $stable(in_sh_reg) && $stable(ones_reg);
  endproperty
  a_ignore_din: assert property (p_ignore_din) else $error("input taken in read"); // [R2]
  property p_msb_in;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg != ash_pkg::ST_READ && sel && rise) |=>
        in_sh_reg[0] == $past(din_s) && in_sh_reg[23:1] == $past(in_sh_reg[22:0]);
  endproperty
  a_msb_in: assert property (p_msb_in) else $error("input order wrong"); // [R3]
  property p_msb_out;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (state_reg == ash_pkg::ST_READ && sel && fall && bit_cnt_reg != 5'h00) |=>
        dout_o == $past(out_sh_reg[22]);
  endproperty
  a_msb_out: assert property (p_msb_out) else $error("output order wrong"); // [R4]
  property p_ready_rise;
    @(posedge core_clk_i) disable iff (!nrst_i)
      s_read_last |=> sample_ready_n_o ##1 (sample_ready_n_o || $past(load));
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready not released"); // [R15]
  property p_ready_fall;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (sample_ready_n_o && fq.out_valid && state_reg == ash_pkg::ST_COMM) |=>
        !sample_ready_n_o && data_reg == $past(fq.out_data);
  endproperty
  a_ready_fall: assert property (p_ready_fall) else $error("new word not shown"); // [R15]
  property p_ones_reset;
    @(posedge core_clk_i) disable iff (!nrst_i)
      (sel && rise && din_s && ones_reg == 6'h1F && state_reg != ash_pkg::ST_READ) |=>
        state_reg == ash_pkg::ST_COMM && bit_cnt_reg == 5'h00 && $stable(setup_reg);
  endproperty
  a_ones_reset: assert property (p_ones_reset) else $error("ones did not reset"); // [R16]
  property p_back_to_back;
    @(posedge core_clk_i) disable iff (!nrst_i)
      s_cmd_read |=> state_reg == ash_pkg::ST_READ && bit_cnt_reg == 5'h00 ##1 dout_oe_o;
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("read not started"); // [R17]
  property p_half_rate;
    @(posedge core_clk_i) disable iff (!nrst_i)
      ($past(clock_reg[ash_pkg::CLK_DIV_BIT]) && clock_reg[ash_pkg::CLK_DIV_BIT] &&
       mod_clk_en_o) |=> !mod_clk_en_o;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("enable not halved"); // [R12]
endmodule

// file: test/ash_host_model.sv
`timescale 1ns/10ps
// ==========================================================
// host end of the serial link: master, clock rests high between frames
module ash_host_model #(
  parameter int HALF = 42
) (
  input  wire logic core_clk_i,
  input  wire logic line_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      drv_o,
  output logic      drv_oe_o
);
  logic rfs_n;
  logic tfs_n;

  // select is active while either active-low frame sync is active
  assign cs_n_o = rfs_n & tfs_n;

  initial begin
    sclk_o = 1'h1;
    {rfs_n, tfs_n, drv_o, drv_oe_o} = 4'hE;
  end

  // ==========================================================
  // one frame: the first nwr bits are driven, the rest released and sampled
  // half period of 42 core cycles keeps the clock just under 3 MHz
  task automatic frame(input logic [31:0] val, input int nbits, input int nwr,
                       output logic [31:0] got);
    got = 32'h0;
    @(negedge core_clk_i);
    drv_oe_o = nwr > 0;
    tfs_n = 1'h0;
    repeat (HALF) @(negedge core_clk_i);
    for (int k = 0; k < nbits; k++) begin
      sclk_o = 1'h0;
      drv_o = val[nbits-1-k];
      repeat (HALF) @(negedge core_clk_i);
      sclk_o = 1'h1;
      got = {got[30:0], line_i};
      // hold the bit one core cycle past the rise so the device samples it,
      // then let go well before the device turns the wire round
      @(negedge core_clk_i);
      drv_oe_o = k + 1 < nwr;
      rfs_n = drv_oe_o;
      tfs_n = !drv_oe_o;
      repeat (HALF - 1) @(negedge core_clk_i);
    end
    {rfs_n, tfs_n, drv_oe_o} = 3'h6;
    repeat (HALF) @(negedge core_clk_i);
  endtask
endmodule

// file: test/ash_serial_port_bench.sv
`timescale 1ns/10ps
module ash_serial_port_bench;
  typedef struct packed {
    logic [2:0]  rs;
    logic [4:0]  len;
    logic [23:0] val;
    logic        cal;
  } ash_row_s;
  localparam ash_row_s ROWS [4] = '{
    '{ash_pkg::RS_CLOCK, ash_pkg::LEN_BYTE, 24'h00000C, 1'h0},
    '{ash_pkg::RS_SETUP, ash_pkg::LEN_BYTE, 24'h000040, 1'h1},
    '{ash_pkg::RS_OFFSET, ash_pkg::LEN_WIDE, 24'h123456, 1'h0},
    '{ash_pkg::RS_GAIN, ash_pkg::LEN_WIDE, 24'hABCDEF, 1'h0}
  };
  logic        core_clk_i, nrst_i, sclk, cs_n, drv, drv_oe;
  logic        dout, dout_oe, ready_n, word_ready, standby, fsh, calib, mod_en;
  logic        sample_valid_i;
  logic [15:0] sample_word_i;
  logic [1:0]  channel;
  logic [7:0]  setup, clock_cfg;
  logic [23:0] offset, gain;
  int          num_errors = 0;
  int          compares = 0;
  int          calib_cnt = 0;
  // shared data wire with pull-up: device drives only during reads
  wire logic   line = dout_oe ? dout : (drv_oe ? drv : 1'h1);

  ash_serial_port ash_serial_port_inst (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(line),
    .dout_o(dout), .dout_oe_o(dout_oe), .sample_ready_n_o(ready_n),
    .sample_word_i(sample_word_i), .sample_valid_i(sample_valid_i), .word_ready_o(word_ready),
    .channel_o(channel), .standby_o(standby), .setup_o(setup), .clock_cfg_o(clock_cfg),
    .offset_o(offset), .gain_o(gain), .filter_sync_hold_o(fsh), .calib_start_o(calib),
    .mod_clk_en_o(mod_en));
  ash_host_model host_inst (
    .core_clk_i(core_clk_i), .line_i(line), .sclk_o(sclk), .cs_n_o(cs_n),
    .drv_o(drv), .drv_oe_o(drv_oe));

  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] cmd(input logic [2:0] rs, input logic rd);
    cmd = {1'h0, rs, rd, 3'h0};
  endfunction
  task automatic wr_reg(input logic [2:0] rs, input logic [4:0] len, input logic [23:0] v);
    logic [31:0] g;
    host_inst.frame(({24'h0, cmd(rs, 1'h0)} << len) | {8'h0, v}, 8 + len, 8 + len, g);
  endtask
  task automatic rd_reg(input logic [2:0] rs, input logic [4:0] len, output logic [23:0] v);
    logic [31:0] g;
    host_inst.frame({24'h0, cmd(rs, 1'h1)} << len, 8 + len, 8, g);
    v = g[23:0] & ~(24'hFFFFFF << len);
  endtask
  function automatic logic [23:0] port_of(input logic [2:0] rs);
    case (rs)
      ash_pkg::RS_SETUP: port_of = {16'h0, setup};
      ash_pkg::RS_CLOCK: port_of = {16'h0, clock_cfg};
      ash_pkg::RS_OFFSET: port_of = offset;
      default: port_of = gain;
    endcase
  endfunction
  // push until refused or n words; ready is read at the falling edge before its sample
  task automatic push_burst(input int n, output int taken);
    taken = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk_i);
      if (word_ready !== 1'h1) break;
      sample_valid_i = 1'h1;
      sample_word_i = 16'hC000 + 16'(taken);
      taken++;
    end
    @(negedge core_clk_i);
    sample_valid_i = 1'h0;
  endtask
  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ==========================================================
  // clock, monitors, watchdog
  initial begin
    core_clk_i = 1'h0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // pulse counter, and no device drive while the host owns the wire
  always @(posedge core_clk_i) begin
    if (calib === 1'h1) calib_cnt <= calib_cnt + 1;
    if (drv_oe === 1'h1 && dout_oe !== 1'h0) begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, dout_oe, 1'h0);
    end
  end
  // run needs about 96k cycles, mostly the slow drain
  initial begin
    repeat (105000) @(posedge core_clk_i);
    num_errors++;
    $display("watchdog expired");
    print_verdict();
  end

  // ==========================================================
  // tests
  initial begin
    ash_row_s    r;
    logic [23:0] v;
    logic        m;
    int          c0;
    int          taken;
    nrst_i = 1'h0;
    sample_valid_i = 1'h0;
    sample_word_i = 16'h0000;
    repeat (10) @(negedge core_clk_i);
    check({dout_oe, ready_n, word_ready, mod_en, calib}, 5'h08);
    check({setup, clock_cfg, channel, standby}, 19'h0);
    check(offset | gain, 24'h0);
    nrst_i = 1'h1;
    repeat (4) @(negedge core_clk_i);
    check({word_ready, ready_n}, 2'h3);
    $display("test reset done");
    // power-up sequence and register write/read round trips
    foreach (ROWS[i]) begin
      r = ROWS[i];
      c0 = calib_cnt;
      wr_reg(r.rs, r.len, r.val);
      repeat (4) @(negedge core_clk_i);
      check(port_of(r.rs), r.val);
      check(calib_cnt - c0, r.cal);
      rd_reg(r.rs, r.len, v);
      check(v, r.val);
      $display("test row %0d done", i);
    end
    // divide bit set by the 0x0C row: enable alternates; cleared: steady
    m = mod_en;
    @(negedge core_clk_i);
    check(m ^ mod_en, 1'h1);
    wr_reg(ash_pkg::RS_CLOCK, ash_pkg::LEN_BYTE, 24'h000004);
    repeat (4) @(negedge core_clk_i);
    m = mod_en;
    @(negedge core_clk_i);
    check({m, mod_en}, 2'h3);
    $display("test clock divide done");
    // command write to the command register: standby and channel land, port stays idle
    host_inst.frame(32'h00000006, 8, 8, v);
    repeat (4) @(negedge core_clk_i);
    check({channel, standby}, 3'h5);
    $display("test command fields done");
    // absorbed data write left pending, then a frame of 32 ones
    host_inst.frame({24'h0, cmd(ash_pkg::RS_DATA, 1'h0)}, 8, 8, v);
    host_inst.frame(32'hFFFFFFFF, 32, 32, v);
    check({setup, clock_cfg}, 16'h4004);
    c0 = calib_cnt;
    wr_reg(ash_pkg::RS_SETUP, ash_pkg::LEN_BYTE, 24'h000001);
    repeat (4) @(negedge core_clk_i);
    check({setup, fsh, 8'(calib_cnt - c0)}, {8'h01, 1'h1, 8'h00});
    $display("test ones reset done");
    // fill until refused, then drain in order while polling the pin
    push_burst(40, taken);
    check(taken, ash_pkg::FIFO_DEPTH + 1);
    check(word_ready, 1'h0);
    rd_reg(ash_pkg::RS_COMM, ash_pkg::LEN_BYTE, v);
    check(v[7], 1'h0);
    for (int k = 0; k < taken; k++) begin
      for (int i = 0; i < 3000 && ready_n !== 1'h0; i++) @(negedge core_clk_i);
      check(ready_n, 1'h0);
      rd_reg(ash_pkg::RS_DATA, ash_pkg::LEN_WORD, v);
      check(v, 16'hC000 + k);
    end
    repeat (8) @(negedge core_clk_i);
    check({ready_n, word_ready}, 2'h3);
    rd_reg(ash_pkg::RS_COMM, ash_pkg::LEN_BYTE, v);
    check(v[7], 1'h1);
    $display("test fill and drain done");
    print_verdict();
  end
endmodule
